// >>> rtl/bld_cfg.svh
// constants for the low-battery detector and heavy-load control block
`ifndef BLD_CFG_SVH
`define BLD_CFG_SVH

`define BLD_CLK_HZ      125000000
`define BLD_OSC_HZ      32768
`define BLD_OSC_DIV     (`BLD_CLK_HZ / `BLD_OSC_HZ)
`define BLD_TAP_HZ      2
`define BLD_TAP_HALF    (`BLD_OSC_HZ / (2 * `BLD_TAP_HZ))
`define BLD_WIN_OSC     4

`define BLD_CTRL_IDX    12'h0fa
`define BLD_STAT_IDX    12'h0fb
`define BLD_MASK_IDX    12'h0fc
`define BLD_CTRL_ADDR   (`BLD_CTRL_IDX << 2)
`define BLD_STAT_ADDR   (`BLD_STAT_IDX << 2)
`define BLD_MASK_ADDR   (`BLD_MASK_IDX << 2)

`define BLD_ON_POS      0
`define BLD_RES_POS     1
`define BLD_HL_POS      3
`define BLD_CTRL_RST    4'h0

`define BLD_EV_SAMPLE   0
`define BLD_EV_LOW      1
`define BLD_EV_AUTO     2
`define BLD_EV_RST      3'h0

`define BLD_RESP_OKAY   2'b00
`define BLD_RESP_SLVERR 2'b10

`endif

// >>> rtl/bld_ctrl.sv
// low-battery detector control, heavy-load mode and AXI4-Lite registers
`timescale 1ns/1ps
`include "bld_cfg.svh"

module bld_ctrl
    import bld_pkg::*;
#(
    parameter int TAP_HALF = `BLD_TAP_HALF
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // analog detector
    input  wire logic        detector_low,
    output logic             detector_enable,
    // mode and interrupt
    output logic             heavy_load_mode,
    output logic             irq
);
    // prescaler enables and synchronised detector level
    logic        osc_tick;
    logic        tap_rise;
    logic        det_low_s;

    // control register fields and heavy-load mode state
    logic        detector_on_bit;
    logic        detector_result_bit;
    logic        heavy_load_mode_bit;
    logic        heavy_reg;

    // sampling window
    bld_win_e    win_state_reg;
    logic [2:0]  win_cnt_reg;
    logic        win_end_reg;

    // write channel holding
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [11:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        do_write;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_mask;

    // events and read mux
    logic [2:0]  stat_reg;
    logic [2:0]  mask_reg;
    logic [2:0]  ev_now;
    logic        manual_latch;
    logic        new_result;
    logic        result_next;
    logic [31:0] rd_mux;
    logic        rd_hit;

    bld_prescale #(
        .OSC_DIV  (`BLD_OSC_DIV),
        .TAP_HALF (TAP_HALF)
    ) u_prescale (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .osc_tick (osc_tick),
        .tap_rise (tap_rise)
    );

    // the detector output is analog-derived and not tied to aclk
    bld_sync #(
        .WIDTH    (1)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (detector_low),
        .sync_out (det_low_s)
    );

    // ---------------- write channels ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            waddr_reg     <= 12'h000;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg   <= 1'b1;
            waddr_reg     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held_reg   <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg   <= 1'b0;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg   <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held_reg   <= 1'b0;
        end else begin
            s_axi_wready <= ~w_held_reg;
        end
    end

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_ctrl  = do_write && wstrb_reg[0] && (waddr_reg == `BLD_CTRL_ADDR);
    assign wr_stat  = do_write && wstrb_reg[0] && (waddr_reg == `BLD_STAT_ADDR);
    assign wr_mask  = do_write && wstrb_reg[0] && (waddr_reg == `BLD_MASK_ADDR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `BLD_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (waddr_reg == `BLD_CTRL_ADDR || waddr_reg == `BLD_STAT_ADDR ||
                waddr_reg == `BLD_MASK_ADDR) begin
                s_axi_bresp <= `BLD_RESP_OKAY;
            end else begin
                s_axi_bresp <= `BLD_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---------------- read channel ----------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `BLD_CTRL_ADDR: begin
                rd_mux[`BLD_HL_POS]  = heavy_load_mode_bit;
                rd_mux[`BLD_RES_POS] = detector_result_bit;
                rd_mux[`BLD_ON_POS]  = detector_on_bit;
            end
            `BLD_STAT_ADDR: begin
                rd_mux[2:0] = stat_reg;
            end
            `BLD_MASK_ADDR: begin
                rd_mux[2:0] = mask_reg;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `BLD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_hit ? `BLD_RESP_OKAY : `BLD_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ---------------- control bits ----------------
    // only D0 and D3 are storage; D1 and D2 write data is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            detector_on_bit     <= 1'(`BLD_CTRL_RST >> `BLD_ON_POS);
            heavy_load_mode_bit <= 1'(`BLD_CTRL_RST >> `BLD_HL_POS);
        end else if (wr_ctrl) begin
            detector_on_bit     <= wdata_reg[`BLD_ON_POS];
            heavy_load_mode_bit <= wdata_reg[`BLD_HL_POS];
        end
    end

    assign manual_latch = wr_ctrl && detector_on_bit && !wdata_reg[`BLD_ON_POS];

    // both paths take the same synchronised detector level
    assign new_result  = manual_latch || win_end_reg;
    assign result_next = det_low_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            detector_result_bit <= 1'(`BLD_CTRL_RST >> `BLD_RES_POS);
        end else if (manual_latch) begin
            detector_result_bit <= result_next;
        end else if (win_end_reg) begin
            detector_result_bit <= result_next;
        end
    end

    // ---------------- heavy-load mode ----------------
    // entries win over the release, so a low sample is never dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            heavy_reg <= 1'b0;
        end else if (wr_ctrl && wdata_reg[`BLD_HL_POS]) begin
            heavy_reg <= 1'b1;
        end else if (new_result && result_next) begin
            heavy_reg <= 1'b1;
        end else if (win_end_reg && !result_next && !heavy_load_mode_bit &&
                     !(wr_ctrl && wdata_reg[`BLD_HL_POS])) begin
            heavy_reg <= 1'b0;
        end
    end

    // ---------------- sampling window ----------------
    // the window is timed in oscillator cycles, not aclk cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_state_reg <= BLD_ST_IDLE;
            win_cnt_reg   <= 3'h0;
            win_end_reg   <= 1'b0;
        end else begin
            win_end_reg <= 1'b0;
            case (win_state_reg)
                BLD_ST_IDLE: begin
                    if (heavy_reg && tap_rise) begin
                        win_state_reg <= BLD_ST_WINDOW;
                        win_cnt_reg   <= 3'h0;
                    end
                end
                BLD_ST_WINDOW: begin
                    if (osc_tick) begin
                        if (win_cnt_reg == 3'(`BLD_WIN_OSC - 1)) begin
                            win_state_reg <= BLD_ST_IDLE;
                            win_end_reg   <= 1'b1;
                        end else begin
                            win_cnt_reg <= win_cnt_reg + 3'h1;
                        end
                    end
                end
                default: begin
                    win_state_reg <= BLD_ST_IDLE;
                end
            endcase
        end
    end

    // ---------------- outputs ----------------
    // a manual request during heavy-load mode still powers the detector;
    // software is expected not to do that
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            detector_enable <= 1'b0;
            heavy_load_mode <= 1'b0;
        end else begin
            detector_enable <= detector_on_bit ||
                               (win_state_reg == BLD_ST_WINDOW);
            heavy_load_mode <= heavy_reg;
        end
    end

    // ---------------- interrupt status ----------------
    always_comb begin
        ev_now                 = 3'h0;
        ev_now[`BLD_EV_SAMPLE] = win_end_reg;
        ev_now[`BLD_EV_LOW]    = new_result && result_next && !detector_result_bit;
        ev_now[`BLD_EV_AUTO]   = new_result && result_next && !heavy_reg;
    end

    // a new event in the clearing cycle stays set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= `BLD_EV_RST;
        end else if (wr_stat) begin
            stat_reg <= (stat_reg & ~wdata_reg[2:0]) | ev_now;
        end else begin
            stat_reg <= stat_reg | ev_now;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg <= `BLD_EV_RST;
        end else if (wr_mask) begin
            mask_reg <= wdata_reg[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_reg & mask_reg);
        end
    end
endmodule

// >>> rtl/bld_pkg.sv
// types shared by the low-battery detector control block
package bld_pkg;
    typedef enum logic {
        BLD_ST_IDLE,
        BLD_ST_WINDOW
    } bld_win_e;
    typedef logic [3:0] bld_nib_t;
endpackage

// >>> rtl/bld_prescale.sv
// oscillator-rate enable and 2 Hz tap rising-edge pulse
`timescale 1ns/1ps
module bld_prescale #(
    parameter int OSC_DIV  = 3814,
    parameter int TAP_HALF = 8192
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // enables
    output logic      osc_tick,
    output logic      tap_rise
);
    logic [11:0] div_reg;
    logic [13:0] tap_cnt_reg;
    logic        tap_reg;

    // one pulse per oscillator period, counted up from the fast clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg  <= 12'h000;
            osc_tick <= 1'b0;
        end else if (div_reg == 12'(OSC_DIV - 1)) begin
            div_reg  <= 12'h000;
            osc_tick <= 1'b1;
        end else begin
            div_reg  <= div_reg + 12'h001;
            osc_tick <= 1'b0;
        end
    end

    // 2 Hz square tap; its rising edge starts a sampling window in heavy-load mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap_cnt_reg <= 14'h0000;
            tap_reg     <= 1'b0;
            tap_rise    <= 1'b0;
        end else begin
            tap_rise <= 1'b0;
            if (osc_tick) begin
                if (tap_cnt_reg == 14'(TAP_HALF - 1)) begin
                    tap_cnt_reg <= 14'h0000;
                    tap_reg     <= ~tap_reg;
                    tap_rise    <= ~tap_reg;
                end else begin
                    tap_cnt_reg <= tap_cnt_reg + 14'h0001;
                end
            end
        end
    end
endmodule

// >>> rtl/bld_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module bld_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // level in and out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// >>> verif/battery_low_detect_heavy_load_ctrl_tb.sv
// self-checking bench for the detector control block
`timescale 1ns/1ps
`include "bld_cfg.svh"
module battery_low_detect_heavy_load_ctrl_tb;
    localparam logic [11:0] CTRL = `BLD_CTRL_ADDR;
    localparam logic [11:0] STAT = `BLD_STAT_ADDR;
    localparam logic [11:0] MASK = `BLD_MASK_ADDR;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        supply_low = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd_val;
    logic        detector_low, detector_enable, heavy_load_mode, irq;
    int          err_total = 0;
    int          checks = 0;

    always #4 aclk = ~aclk;

    bld_ctrl #(.TAP_HALF(4)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .detector_low(detector_low),
        .detector_enable(detector_enable), .heavy_load_mode(heavy_load_mode), .irq(irq)
    );

    bld_detector_model u_det (
        .aclk(aclk), .supply_low(supply_low),
        .detector_enable(detector_enable), .detector_low(detector_low)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // ready is raised after the address phase, on the same edge that bvalid rises, so the response never waits
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_val = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string w);
        rd(a);
        chk(rd_val, e, w);
    endtask

    // a window already past leaves the mode low, so the wait ends without one
    task automatic wait_win;
        int n;
        n = 0;
        while (!detector_enable && heavy_load_mode && n < 40000) begin
            @(posedge aclk);
            n++;
        end
        while (detector_enable) @(posedge aclk);
        repeat (4) @(posedge aclk);
    endtask

    task automatic final_report;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        // the two windows end near 92k cycles; this leaves a little slack
        repeat (99000) @(posedge aclk);
        err_total++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rchk(CTRL, 32'h0000_0000, "ctrl reset");
        rchk(MASK, 32'h0000_0000, "mask reset");
        wr(CTRL, 32'h0000_0007);
        rchk(CTRL, 32'h0000_0001, "on bit only");
        chk(detector_enable, 1'b1, "detector powered");
        repeat (12600) @(posedge aclk);
        wr(CTRL, 32'h0000_0000);
        rchk(CTRL, 32'h0000_0000, "good latched");
        supply_low <= 1'b1;
        wr(CTRL, 32'h0000_0001);
        repeat (12600) @(posedge aclk);
        wr(CTRL, 32'h0000_0000);
        rchk(CTRL, 32'h0000_0002, "low latched");
        chk(heavy_load_mode, 1'b1, "auto heavy entry");
        chk(irq, 1'b0, "irq masked");
        wr(MASK, 32'h0000_0007);
        chk(resp, `BLD_RESP_OKAY, "mapped write okay");
        chk(irq, 1'b1, "irq unmasked");
        rd(STAT);
        chk(rd_val & 32'h0000_0006, 32'h0000_0006, "low and auto events");
        wr(STAT, 32'h0000_0007);
        chk(irq, 1'b0, "irq cleared");
        // software stays off the on bit while heavy mode runs
        supply_low <= 1'b0;
        wait_win();
        rchk(CTRL, 32'h0000_0000, "sample written");
        chk(heavy_load_mode, 1'b0, "auto heavy left");
        rchk(STAT, 32'h0000_0001, "sample done event only");
        wr(CTRL, 32'h0000_0008);
        chk(heavy_load_mode, 1'b1, "heavy by software");
        rchk(CTRL, 32'h0000_0008, "mode bit reads back");
        wr(CTRL, 32'h0000_0000);
        chk(heavy_load_mode, 1'b1, "heavy held after clear");
        wait_win();
        chk(heavy_load_mode, 1'b0, "heavy left at window");
        wr(12'h000, 32'h0000_0008);
        chk(resp, `BLD_RESP_SLVERR, "unmapped write");
        chk(heavy_load_mode, 1'b0, "unmapped write no effect");
        rd(12'h000);
        chk(resp, `BLD_RESP_SLVERR, "unmapped read");
        final_report();
    end
endmodule

// >>> verif/bld_ctrl_monitor.sv
// concurrent checks on the detector control block ports
`timescale 1ns/1ps
`include "bld_cfg.svh"
module bld_ctrl_monitor #(
    parameter int TAP_HALF = 4
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // detector and mode
    input wire logic        detector_enable,
    input wire logic        heavy_load_mode,
    input wire logic        irq
);
    // four ticks of 3814 clocks; slack covers the tick phase at window start
    localparam int WIN_MIN = 15000;
    localparam int WIN_MAX = 15300;
    int   en_cnt;
    int   off_cnt;
    logic rd_ctrl;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_cnt  <= 0;
            off_cnt <= 100;
            rd_ctrl <= 1'b0;
        end else begin
            en_cnt  <= detector_enable ? en_cnt + 1 : 0;
            off_cnt <= detector_enable ? 0 : (off_cnt < 100 ? off_cnt + 1 : off_cnt);
            if (s_axi_arvalid && s_axi_arready)
                rd_ctrl <= (s_axi_araddr == `BLD_CTRL_ADDR);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_ctrl;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == `BLD_CTRL_ADDR;
    endsequence
    sequence s_win_end;
        $fell(detector_enable) && $past(heavy_load_mode, 2);
    endsequence

    property p_rst_clear;
        $rose(aresetn) |-> !heavy_load_mode && !detector_enable && !irq && !s_axi_bvalid;
    endproperty
    property p_on;
        s_wr_ctrl ##0 s_axi_wdata[0] |-> ##[1:3] detector_enable;
    endproperty
    property p_hl_on;
        s_wr_ctrl ##0 s_axi_wdata[3] |-> ##[1:3] heavy_load_mode;
    endproperty
    property p_rd_fixed;
        s_axi_rvalid && rd_ctrl |-> s_axi_rdata[31:4] == 28'h000_0000 && !s_axi_rdata[2];
    endproperty
    property p_rd_hl;
        s_axi_rvalid && rd_ctrl && s_axi_rdata[3] |-> heavy_load_mode;
    endproperty
    property p_win_len;
        s_win_end |-> en_cnt >= WIN_MIN && en_cnt <= WIN_MAX;
    endproperty
    property p_hl_fall;
        $fell(heavy_load_mode) |-> !detector_enable && off_cnt <= 4;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty

    a_rst_clear: assert property (p_rst_clear)
        else $error("outputs not clear after reset");
    a_on: assert property (p_on)
        else $error("detector not powered by on bit");
    a_hl_on: assert property (p_hl_on)
        else $error("heavy mode not entered on write");
    a_rd_fixed: assert property (p_rd_fixed)
        else $error("fixed control bits not zero");
    a_rd_hl: assert property (p_rd_hl)
        else $error("mode bit set but mode inactive");
    a_win_len: assert property (p_win_len)
        else $error("sampling window length wrong");
    a_hl_fall: assert property (p_hl_fall)
        else $error("heavy mode left outside a window end");
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
endmodule

bind bld_ctrl bld_ctrl_monitor #(.TAP_HALF(TAP_HALF)) u_monitor (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .detector_enable(detector_enable), .heavy_load_mode(heavy_load_mode), .irq(irq)
);

// >>> verif/bld_detector_model.sv
// behavioural analog low-battery detector behind the enable line
`timescale 1ns/1ps
module bld_detector_model (
    // clock
    input  wire logic aclk,
    // supply state and detector power
    input  wire logic supply_low,
    input  wire logic detector_enable,
    // comparator output
    output logic      detector_low = 1'b0
);
    int off_cnt = 0;

    // unpowered output is junk: toggling keeps a stale value from passing as a sample
    always @(posedge aclk) begin
        if (detector_enable) begin
            off_cnt <= 0;
            detector_low <= supply_low;
        end else if (off_cnt < 4) begin
            off_cnt <= off_cnt + 1;
        end else begin
            detector_low <= ~detector_low;
        end
    end
endmodule
